// File: pkg/qcm_pkg.sv
// ----------------------------------------------------------------
// quadrature counter shared definitions
// ----------------------------------------------------------------
package qcm_pkg;

  localparam int QCM_CNT_W = 32;
  localparam int QCM_ADDR_W = 8;
  localparam int QCM_GROUPS = 4;
  localparam int QCM_GROUP_STRIDE = 4;
  localparam int QCM_IRQ_W = 3;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [QCM_ADDR_W-1:0] QCM_CTRL_OFS = 8'h00;
  localparam logic [QCM_ADDR_W-1:0] QCM_COMPARE_OFS = 8'h04;
  localparam logic [QCM_ADDR_W-1:0] QCM_PRELOAD_OFS = 8'h08;
  localparam logic [QCM_ADDR_W-1:0] QCM_COUNT_OFS = 8'h0c;
  localparam logic [QCM_ADDR_W-1:0] QCM_STROBE_OFS = 8'h10;
  localparam logic [QCM_ADDR_W-1:0] QCM_SYNC_STATUS_OFS = 8'h14;
  localparam logic [QCM_ADDR_W-1:0] QCM_DONE_OFS = 8'h18;
  localparam logic [QCM_ADDR_W-1:0] QCM_ACK_OFS = 8'h1c;
  localparam logic [QCM_ADDR_W-1:0] QCM_IRQ_STATUS_OFS = 8'h20;
  localparam logic [QCM_ADDR_W-1:0] QCM_IRQ_MASK_OFS = 8'h24;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int QCM_CTRL_MODE_LSB = 0;
  localparam int QCM_CTRL_RUN_BIT = 2;
  localparam int QCM_CTRL_CNT_HOLD_BIT = 3;
  localparam int QCM_CTRL_OUT_HOLD_BIT = 4;
  localparam int QCM_CTRL_SYNC_EN_LSB = 8;
  localparam int QCM_MARKER_FLAG_BIT = 1;
  localparam int QCM_IRQ_MARKER_BIT = 0;
  localparam int QCM_IRQ_STROBE_BIT = 1;
  localparam int QCM_IRQ_SYNC_BIT = 2;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] QCM_CTRL_RST = 32'h0000_0000;
  localparam logic [QCM_CNT_W-1:0] QCM_CNT_RST = 32'h0000_0000;
  localparam logic [15:0] QCM_WORD_RST = 16'h0000;
  localparam logic [QCM_IRQ_W-1:0] QCM_IRQ_RST = 3'h0;

  typedef enum logic [1:0] {
    QCM_MODE0 = 2'h0,
    QCM_MODE1 = 2'h1,
    QCM_MODE2 = 2'h2,
    QCM_MODE3 = 2'h3
  } qcm_mode_t;

  typedef enum logic [2:0] {
    QCM_MK_IDLE = 3'b001,
    QCM_MK_CLEAR = 3'b010,
    QCM_MK_SHOW = 3'b100
  } qcm_mk_state_t;

  typedef struct packed {
    logic phase_a;
    logic phase_b;
    logic marker;
    logic preload;
    logic prestrobe;
  } qcm_pins_t;

endpackage : qcm_pkg

// File: core/qcm_counter.sv
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/1ns
`default_nettype none
module qcm_counter
  import qcm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [QCM_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic phase_a_terminal,
  input wire logic phase_b_terminal,
  input wire logic marker_terminal,
  input wire logic preload_terminal,
  input wire logic prestrobe_terminal,
  output logic [QCM_GROUPS-1:0] sync_out,
  output logic irq
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  qcm_pins_t pins_raw;
  qcm_pins_t pins_meta_reg;
  qcm_pins_t pins_sync_reg;
  qcm_pins_t pins_prev_reg;

  assign pins_raw = '{phase_a: phase_a_terminal, phase_b: phase_b_terminal,
                      marker: marker_terminal, preload: preload_terminal,
                      prestrobe: prestrobe_terminal};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_meta_reg <= '0;
      pins_sync_reg <= '0;
      pins_prev_reg <= '0;
    end else if (ce) begin
      pins_meta_reg <= pins_raw;
      pins_sync_reg <= pins_meta_reg;
      pins_prev_reg <= pins_sync_reg;
    end
  end

  logic a_lvl, b_lvl, a_rise, a_fall, b_rise, b_fall;
  logic marker_evt, preload_evt, strobe_evt;

  assign a_lvl = pins_sync_reg.phase_a;
  assign b_lvl = pins_sync_reg.phase_b;
  assign a_rise = a_lvl & ~pins_prev_reg.phase_a;
  assign a_fall = ~a_lvl & pins_prev_reg.phase_a;
  assign b_rise = b_lvl & ~pins_prev_reg.phase_b;
  assign b_fall = ~b_lvl & pins_prev_reg.phase_b;
  // only the dedicated marker terminal feeds the clear
  assign marker_evt = pins_sync_reg.marker & ~pins_prev_reg.marker;
  assign preload_evt = pins_sync_reg.preload & ~pins_prev_reg.preload;
  assign strobe_evt = pins_sync_reg.prestrobe & ~pins_prev_reg.prestrobe;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [31:0] ctrl_reg;
  logic [QCM_CNT_W-1:0] compare_reg;
  logic [QCM_CNT_W-1:0] preload_reg;
  logic [QCM_CNT_W-1:0] count_reg;
  logic [QCM_CNT_W-1:0] strobe_reg;
  logic [15:0] ack_reg;
  logic [QCM_IRQ_W-1:0] irq_status_reg;
  logic [QCM_IRQ_W-1:0] irq_mask_reg;
  qcm_mk_state_t mk_state_reg;
  qcm_mk_state_t mk_state_next;

  qcm_mode_t mode;
  logic run, cnt_hold, out_hold;
  logic [QCM_GROUPS-1:0] sync_en;

  assign mode = qcm_mode_t'(ctrl_reg[QCM_CTRL_MODE_LSB +: 2]);
  assign run = ctrl_reg[QCM_CTRL_RUN_BIT];
  assign cnt_hold = ctrl_reg[QCM_CTRL_CNT_HOLD_BIT];
  assign out_hold = ctrl_reg[QCM_CTRL_OUT_HOLD_BIT];
  assign sync_en = ctrl_reg[QCM_CTRL_SYNC_EN_LSB +: QCM_GROUPS];

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  logic acc_done, wr_done, rd_done, addr_ok;
  logic [31:0] rd_mux;
  logic [15:0] sync_status_word;
  logic [15:0] done_word;

  assign acc_done = psel & penable & pready;
  assign wr_done = acc_done & pwrite & addr_ok;
  assign rd_done = acc_done & ~pwrite & addr_ok;

  always_comb begin
    addr_ok = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      QCM_CTRL_OFS: rd_mux = ctrl_reg;
      QCM_COMPARE_OFS: rd_mux = compare_reg;
      QCM_PRELOAD_OFS: rd_mux = preload_reg;
      QCM_COUNT_OFS: rd_mux = count_reg;
      QCM_STROBE_OFS: rd_mux = strobe_reg;
      QCM_SYNC_STATUS_OFS: rd_mux = {16'h0000, sync_status_word};
      QCM_DONE_OFS: rd_mux = {16'h0000, done_word};
      QCM_ACK_OFS: rd_mux = {16'h0000, ack_reg};
      QCM_IRQ_STATUS_OFS: rd_mux = {29'h0000_0000, irq_status_reg};
      QCM_IRQ_MASK_OFS: rd_mux = {29'h0000_0000, irq_mask_reg};
      default: addr_ok = 1'b0;
    endcase
  end

  // one wait state keeps the read data path registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready <= psel & penable & ~pready;
      if (psel & penable & ~pready) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_mux;
        pslverr <= ~addr_ok;
      end else begin
        prdata <= 32'h0000_0000;
        pslverr <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= QCM_CTRL_RST;
      compare_reg <= QCM_CNT_RST;
      preload_reg <= QCM_CNT_RST;
      ack_reg <= QCM_WORD_RST;
      irq_mask_reg <= QCM_IRQ_RST;
    end else if (ce && wr_done) begin
      case (paddr)
        QCM_CTRL_OFS: ctrl_reg <= pwdata;
        QCM_COMPARE_OFS: compare_reg <= pwdata;
        QCM_PRELOAD_OFS: preload_reg <= pwdata;
        QCM_ACK_OFS: ack_reg <= pwdata[15:0] & (16'h0001 << QCM_MARKER_FLAG_BIT);
        QCM_IRQ_MASK_OFS: irq_mask_reg <= pwdata[QCM_IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // quadrature decode
  // ----------------------------------------------------------------
  logic step_up, step_dn;

  always_comb begin
    step_up = 1'b0;
    step_dn = 1'b0;
    case (mode)
      QCM_MODE0: begin
        step_up = (b_rise & a_lvl) | (b_fall & ~a_lvl) | (a_fall & b_lvl) | (a_rise & ~b_lvl);
        step_dn = (b_rise & ~a_lvl) | (b_fall & a_lvl) | (a_fall & ~b_lvl) | (a_rise & b_lvl);
      end
      QCM_MODE1: begin
        step_up = a_rise & ~b_lvl;
        step_dn = a_rise & b_lvl;
      end
      QCM_MODE2: begin
        step_up = a_rise & ~b_lvl;
        step_dn = b_rise & ~a_lvl;
      end
      QCM_MODE3: begin
        step_up = (b_rise & a_lvl) | (b_fall & ~a_lvl);
        step_dn = (b_rise & ~a_lvl) | (b_fall & a_lvl);
      end
      default: ;
    endcase
  end

  // ----------------------------------------------------------------
  // count value
  // ----------------------------------------------------------------
  // both phases moving in one sample is illegal; up and down cancel out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= QCM_CNT_RST;
    end else if (ce) begin
      if (!run) begin
        if (!cnt_hold) begin
          count_reg <= QCM_CNT_RST;
        end
      end else if (marker_evt) begin
        count_reg <= QCM_CNT_RST;
      end else if (preload_evt) begin
        count_reg <= preload_reg;
      end else if (step_up & ~step_dn) begin
        count_reg <= count_reg + 32'h0000_0001;
      end else if (step_dn & ~step_up) begin
        count_reg <= count_reg - 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strobe_reg <= QCM_CNT_RST;
    end else if (ce && strobe_evt) begin
      strobe_reg <= count_reg;
    end
  end

  // ----------------------------------------------------------------
  // synchronous outputs
  // ----------------------------------------------------------------
  // group 0 follows the compare; others have no counter here, enable only
  logic [QCM_GROUPS-1:0] sync_want;
  assign sync_want = {sync_en[QCM_GROUPS-1:1], sync_en[0] & (count_reg >= compare_reg)};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_out <= '0;
    end else if (ce) begin
      for (int g = 0; g < QCM_GROUPS; g++) begin
        if (sync_en[g] || !out_hold) begin
          sync_out[g] <= sync_want[g];
        end
      end
    end
  end

  always_comb begin
    sync_status_word = QCM_WORD_RST;
    for (int g = 0; g < QCM_GROUPS; g++) begin
      sync_status_word[g*QCM_GROUP_STRIDE] = sync_out[g];
    end
  end

  // ----------------------------------------------------------------
  // marker handshake
  // ----------------------------------------------------------------
  always_comb begin
    mk_state_next = mk_state_reg;
    case (mk_state_reg)
      QCM_MK_IDLE: begin
        if (run && marker_evt) begin
          mk_state_next = QCM_MK_CLEAR;
        end
      end
      QCM_MK_CLEAR: begin
        mk_state_next = QCM_MK_SHOW;
      end
      QCM_MK_SHOW: begin
        // a new clear beats a pending acknowledge
        if (run && marker_evt) begin
          mk_state_next = QCM_MK_CLEAR;
        end else if (ack_reg[QCM_MARKER_FLAG_BIT]) begin
          mk_state_next = QCM_MK_IDLE;
        end
      end
      default: mk_state_next = QCM_MK_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mk_state_reg <= QCM_MK_IDLE;
    end else if (ce) begin
      mk_state_reg <= mk_state_next;
    end
  end

  // display held through a re-clear so the host never misses one
  assign done_word = (mk_state_reg == QCM_MK_IDLE) ? QCM_WORD_RST :
                     (16'h0001 << QCM_MARKER_FLAG_BIT);

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  logic [QCM_IRQ_W-1:0] irq_set;
  logic irq_rd_clr;

  assign irq_set[QCM_IRQ_MARKER_BIT] = (mk_state_reg == QCM_MK_CLEAR);
  assign irq_set[QCM_IRQ_STROBE_BIT] = strobe_evt;
  assign irq_set[QCM_IRQ_SYNC_BIT] = sync_want[0] & ~sync_out[0];
  assign irq_rd_clr = rd_done && (paddr == QCM_IRQ_STATUS_OFS);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_reg <= QCM_IRQ_RST;
    end else if (ce) begin
      irq_status_reg <= (irq_rd_clr ? QCM_IRQ_RST : irq_status_reg) | irq_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= |(irq_status_reg & irq_mask_reg);
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic quiet;
  assign quiet = ce & run & ~marker_evt & ~preload_evt;

  sequence marker_hit_s;
    ce && run && marker_evt;
  endsequence

  sequence show_reached_s;
    ce ##1 (mk_state_reg == QCM_MK_SHOW);
  endsequence

  status_layout_a: assert property ((sync_status_word & 16'heeee) == 16'h0000)
    else $error("status word has bits outside group positions");

  status_follow_a: assert property (sync_status_word[4] == sync_out[1]
                                    && sync_status_word[12] == sync_out[3])
    else $error("status bit does not follow sync output");

  mode0_up_a: assert property (quiet && mode == QCM_MODE0 && b_rise && a_lvl
                               && !a_rise && !a_fall |=> count_reg == $past(count_reg) + 1)
    else $error("mode 0 missed up count");

  mode0_dn_a: assert property (quiet && mode == QCM_MODE0 && a_rise && b_lvl
                               && !b_rise && !b_fall |=> count_reg == $past(count_reg) - 1)
    else $error("mode 0 missed down count");

  mode1_idle_a: assert property (quiet && mode == QCM_MODE1 && !a_rise
                                 |=> $stable(count_reg))
    else $error("mode 1 counted without a rising");

  mode2_dn_a: assert property (quiet && mode == QCM_MODE2 && b_rise && !a_lvl && !a_rise
                               |=> count_reg == $past(count_reg) - 1)
    else $error("mode 2 missed down count");

  mode3_a_idle_a: assert property (quiet && mode == QCM_MODE3 && !b_rise && !b_fall
                                   |=> $stable(count_reg))
    else $error("mode 3 counted on a edge");

  marker_clear_a: assert property (marker_hit_s |=> count_reg == QCM_CNT_RST)
    else $error("marker did not clear count");

  done_set_a: assert property (marker_hit_s ##1 ce |=> done_word[QCM_MARKER_FLAG_BIT])
    else $error("done flag not set after clear");

  done_hold_a: assert property (done_word[QCM_MARKER_FLAG_BIT] && !ack_reg[QCM_MARKER_FLAG_BIT]
                                |=> done_word[QCM_MARKER_FLAG_BIT])
    else $error("done flag cleared without ack");

  done_path_a: assert property (marker_hit_s |=> (mk_state_reg == QCM_MK_CLEAR) ##0 show_reached_s
                                or !ce)
    else $error("handshake sequence broken");

endmodule : qcm_counter
`default_nettype wire

// File: verif/qcm_encoder_model.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------
// encoder and external pins model
// ----------------------------------------------------------------
module qcm_encoder_model (
  input wire logic pclk,
  output logic phase_a,
  output logic phase_b,
  output logic marker,
  output logic preload,
  output logic prestrobe
);
  initial begin
    phase_a = 1'b0;
    phase_b = 1'b0;
    marker = 1'b0;
    preload = 1'b0;
    prestrobe = 1'b0;
  end

  // held 6 cycles: well past the 2-cycle spacing the synchronisers need
  task automatic toggle(input logic on_a);
    @(posedge pclk);
    if (on_a) begin
      phase_a <= !phase_a;
    end else begin
      phase_b <= !phase_b;
    end
    repeat (6) @(posedge pclk);
  endtask : toggle

  // 0 marker, 1 preload, other prestrobe
  task automatic pulse(input int which);
    @(posedge pclk);
    case (which)
      0: marker <= 1'b1;
      1: preload <= 1'b1;
      default: prestrobe <= 1'b1;
    endcase
    repeat (6) @(posedge pclk);
    marker <= 1'b0;
    preload <= 1'b0;
    prestrobe <= 1'b0;
    repeat (6) @(posedge pclk);
  endtask : pulse
endmodule : qcm_encoder_model
`default_nettype wire

// File: verif/quadrature_counter_marker_clear_test.sv
`timescale 1ns/1ns
`default_nettype none
module quadrature_counter_marker_clear_test;
  import qcm_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [QCM_ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata, rd, exp, w;
  logic pready, pslverr, err, on_a, irq;
  logic phase_a, phase_b, marker, preload, prestrobe;
  logic [QCM_GROUPS-1:0] sync_out;
  logic ce = 1'b1;
  int fails = 0;
  int check_count = 0;

  always #10 pclk = ~pclk;

  qcm_counter dut_u (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .phase_a_terminal(phase_a),
    .phase_b_terminal(phase_b), .marker_terminal(marker), .preload_terminal(preload),
    .prestrobe_terminal(prestrobe), .sync_out(sync_out), .irq(irq));

  qcm_encoder_model enc_u (.pclk(pclk), .phase_a(phase_a), .phase_b(phase_b),
    .marker(marker), .preload(preload), .prestrobe(prestrobe));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] want, input string what);
    check_count++;
    if (got !== want) begin
      fails++;
      $display("FAIL t=%0t %s got %h want %h", $time, what, got, want);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [QCM_ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // count step for one edge: a_edge edge is on phase a, oth is the other phase
  function automatic logic [31:0] step_of(input logic [1:0] m, input logic a_edge,
      input logic rise, input logic oth);
    logic up, dn;
    up = 1'b0;
    dn = 1'b0;
    case (m)
      2'h0: begin
        up = a_edge ? (rise != oth) : (rise == oth);
        dn = !up;
      end
      2'h1: begin
        up = a_edge && rise && !oth;
        dn = a_edge && rise && oth;
      end
      2'h2: begin
        up = a_edge && rise && !oth;
        dn = !a_edge && rise && !oth;
      end
      default: begin
        up = !a_edge && (rise == oth);
        dn = !a_edge && (rise != oth);
      end
    endcase
    return up ? 32'h1 : (dn ? 32'hffff_ffff : 32'h0);
  endfunction : step_of

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop

  // ----------------------------------------------------------------
  // watchdog: whole sequence needs roughly 950 cycles
  // ----------------------------------------------------------------
  initial begin
    #(20 * 8000);
    fails++;
    report_and_stop();
  end

  initial begin
    void'($urandom(32'h7c26));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, QCM_DONE_OFS, 32'h0);
    chk(rd, 32'h0, "done reset");
    apb(1'b0, QCM_SYNC_STATUS_OFS, 32'h0);
    chk(rd, 32'h0, "status reset");
    apb(1'b0, 8'h3c, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped error");
    $display("test reset done");
    exp = QCM_CNT_RST;
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, QCM_CTRL_OFS, 32'h4 | 32'(m));
      repeat (16) begin
        on_a = 1'($urandom_range(0, 1));
        exp = exp + step_of(2'(m), on_a, on_a ? !phase_a : !phase_b, on_a ? phase_b : phase_a);
        enc_u.toggle(on_a);
        apb(1'b0, QCM_COUNT_OFS, 32'h0);
        chk(rd, exp, "count");
      end
    end
    $display("test modes done");
    apb(1'b1, QCM_CTRL_OFS, 32'h8);
    apb(1'b0, QCM_COUNT_OFS, 32'h0);
    chk(rd, exp, "count held");
    apb(1'b1, QCM_CTRL_OFS, 32'h0);
    apb(1'b0, QCM_COUNT_OFS, 32'h0);
    chk(rd, 32'h0, "count cleared");
    apb(1'b1, QCM_CTRL_OFS, 32'h4);
    w = $urandom | 32'h1;
    apb(1'b1, QCM_PRELOAD_OFS, w);
    enc_u.pulse(1);
    apb(1'b0, QCM_COUNT_OFS, 32'h0);
    chk(rd, w, "preload");
    enc_u.pulse(2);
    apb(1'b0, QCM_STROBE_OFS, 32'h0);
    chk(rd, w, "strobe");
    // a whole marker pulse while frozen must leave no trace
    @(posedge pclk);
    ce <= 1'b0;
    enc_u.pulse(0);
    ce <= 1'b1;
    apb(1'b0, QCM_COUNT_OFS, 32'h0);
    chk(rd, w, "frozen marker ignored");
    apb(1'b0, QCM_DONE_OFS, 32'h0);
    chk(rd, 32'h0, "frozen done idle");
    $display("test hold and preload done");
    apb(1'b1, QCM_IRQ_MASK_OFS, 32'h1);
    enc_u.pulse(0);
    apb(1'b0, QCM_COUNT_OFS, 32'h0);
    chk(rd, 32'h0, "marker clear");
    apb(1'b0, QCM_DONE_OFS, 32'h0);
    chk(rd, 32'h2, "done set");
    chk({31'h0, irq}, 32'h1, "irq raised");
    apb(1'b0, QCM_DONE_OFS, 32'h0);
    chk(rd, 32'h2, "done waits ack");
    apb(1'b1, QCM_ACK_OFS, 32'h2);
    apb(1'b0, QCM_ACK_OFS, 32'h0);
    chk(rd, 32'h2, "ack stored");
    apb(1'b0, QCM_DONE_OFS, 32'h0);
    chk(rd, 32'h0, "done cleared");
    apb(1'b1, QCM_ACK_OFS, 32'h0);
    apb(1'b0, QCM_IRQ_STATUS_OFS, 32'h0);
    // strobe pulse above set bit 1 too; it stays until this read
    chk(rd, 32'h3, "irq status");
    repeat (3) @(posedge pclk);
    chk({31'h0, irq}, 32'h0, "irq cleared by read");
    apb(1'b1, QCM_IRQ_MASK_OFS, 32'h0);
    enc_u.pulse(0);
    chk({31'h0, irq}, 32'h0, "irq masked");
    $display("test marker done");
    apb(1'b1, QCM_COMPARE_OFS, 32'hffff_ffff);
    apb(1'b1, QCM_CTRL_OFS, 32'h0f04);
    repeat (3) @(posedge pclk);
    apb(1'b0, QCM_SYNC_STATUS_OFS, 32'h0);
    chk(rd, 32'h1110, "status below compare");
    chk({28'h0, sync_out}, 32'he, "outputs below compare");
    apb(1'b1, QCM_COMPARE_OFS, 32'h0);
    repeat (3) @(posedge pclk);
    apb(1'b0, QCM_SYNC_STATUS_OFS, 32'h0);
    chk(rd, 32'h1111, "status at compare");
    apb(1'b1, QCM_CTRL_OFS, 32'h14);
    repeat (3) @(posedge pclk);
    apb(1'b0, QCM_SYNC_STATUS_OFS, 32'h0);
    chk(rd, 32'h1111, "status held");
    apb(1'b1, QCM_CTRL_OFS, 32'h4);
    repeat (3) @(posedge pclk);
    apb(1'b0, QCM_SYNC_STATUS_OFS, 32'h0);
    chk(rd, 32'h0, "status disabled");
    $display("test sync status done");
    report_and_stop();
  end
endmodule : quadrature_counter_marker_clear_test
`default_nettype wire
